// ===== vxism_pkg.sv
package vxism_pkg;

   // ----------------------------------------------------------------
   // VXI address spaces and decode.
   // ----------------------------------------------------------------
   localparam logic [1:0] SP_A16 = 2'h0;
   localparam logic [1:0] SP_A24 = 2'h1;
   localparam logic [1:0] SP_A32 = 2'h2;
   localparam logic [1:0] A16_TOP = 2'h3;
   localparam int LA_LSB = 6;
   localparam int PCI_SEL_BIT = 14;

   // ----------------------------------------------------------------
   // Host side register offsets inside the A16 block.
   // ----------------------------------------------------------------
   localparam logic [5:0] V_ID = 6'h00;
   localparam logic [5:0] V_STAT = 6'h04;
   localparam logic [5:0] V_BASE = 6'h06;
   localparam logic [5:0] V_H2C = 6'h08;
   localparam logic [5:0] V_C2H = 6'h0A;
   localparam logic [5:0] V_TRG_LO = 6'h10;
   localparam logic [5:0] V_TRG_HI = 6'h12;

   // ----------------------------------------------------------------
   // Processor side register byte offsets.
   // ----------------------------------------------------------------
   localparam logic [4:0] C_H2C = 5'h00;
   localparam logic [4:0] C_C2H = 5'h04;
   localparam logic [4:0] C_IRQ = 5'h08;
   localparam logic [4:0] C_OPS = 5'h0C;
   localparam logic [4:0] C_STAT = 5'h10;
   localparam logic [4:0] C_MASK = 5'h14;

   // ----------------------------------------------------------------
   // Field positions, identity and reset values.
   // ----------------------------------------------------------------
   localparam int IRQ_EN_BIT = 3;
   localparam int ST_H2C_BIT = 0;
   localparam int ST_C2H_BIT = 1;
   localparam logic [11:0] MFR_ID = 12'hA5A; // Arbitrary value.
   localparam logic [1:0] ID_CLASS = 2'h3;
   localparam logic [1:0] ID_A24 = 2'h0;
   localparam logic [1:0] ID_A32 = 2'h1;
   localparam logic [15:0] BASE_RST = 16'h0000;
   localparam logic [31:0] ROUTE_RST = 32'h0000_0000;
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   // ----------------------------------------------------------------
   // Carriers.
   // ----------------------------------------------------------------
   typedef struct packed {
      logic req;
      logic wr;
      logic [1:0] space;
      logic [31:0] addr;
      logic [31:0] wdata;
   } vxism_vreq_t;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
   } vxism_rsp_t;

   typedef struct packed {
      logic req;
      logic wr;
      logic pci;
      logic [13:0] addr;
      logic [31:0] wdata;
   } vxism_lreq_t;

   typedef struct packed {
      logic [7:0] la_off;
      logic user_off;
      logic launch_off;
      logic update_off;
      logic a32_off;
      logic flash_off;
      logic [2:0] byp_off;
   } vxism_sw_t;

   typedef enum logic [1:0] {ST_IDLE, ST_LB, ST_DONE} vxism_st_t;

endpackage

// ===== vxism_bridge.sv
// What this block does
// - Turn each VXI window cycle into local bus cycle.
// - Whole shared memory reachable in A24/A32 window.
// - A16 handshake registers, also processor read/write.
// - Processor raises VXI interrupt on chosen level.
// - Host-programmed routing from PXI to VXI triggers.
// - Host reaches shared memory, waiting until the local bus answers.
// - Upper window half passes onto on-board PCI.
// - Logical address from switches, OFF is one.
// - User switch readable, ON reads zero.
// - A32 window when switch ON, else A24.
// - Update switch OFF at power-up: update mode.
// - Launch switch OFF starts user application.
// - Flash programming allowed only while switch ON.
// - Bypass switch ON routes scan chain around slot.
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

module vxism_bridge (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic cpu_irq,
   input wire vxism_pkg::vxism_vreq_t vxi_in,
   output var vxism_pkg::vxism_rsp_t vxi_rsp,
   output logic [7:0] vxi_irq,
   output var vxism_pkg::vxism_lreq_t lb_req,
   input wire vxism_pkg::vxism_rsp_t lb_rsp,
   input wire logic [7:0] pxi_trig,
   output logic [7:0] vxi_trig,
   output logic [7:0] vxi_trig_oe,
   input wire vxism_pkg::vxism_sw_t sw_in,
   output logic [7:0] logical_addr,
   output logic a32_mode,
   output logic fw_update_mode,
   output logic launch_user_app,
   output logic flash_wr_en,
   output logic [2:0] jtag_bypass
);
   import vxism_pkg::*;

   // ----------------------------------------------------------------
   // Reset release and input synchronisers.
   // ----------------------------------------------------------------
   logic rst_s1;
   logic rst_n;
   vxism_vreq_t v_s1;
   vxism_vreq_t v_s2;
   vxism_sw_t sw_s1;
   vxism_sw_t sw_s2;
   logic [7:0] pt_s1;
   logic [7:0] pt_s2;

   // Reset is applied at once and released through two flip-flops.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // Host, switch and trigger pins pass two flip-flops; request and data share the delay.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         v_s1 <= '0;
         v_s2 <= '0;
         sw_s1 <= '0;
         sw_s2 <= '0;
         pt_s1 <= 8'h00;
         pt_s2 <= 8'h00;
      end else begin
         v_s1 <= vxi_in;
         v_s2 <= v_s1;
         sw_s1 <= sw_in;
         sw_s2 <= sw_s1;
         pt_s1 <= pxi_trig;
         pt_s2 <= pt_s1;
      end
   end

   // ----------------------------------------------------------------
   // State of the bridge.
   // ----------------------------------------------------------------
   vxism_st_t st_r, st_nxt;
   vxism_rsp_t vrsp_r, vrsp_nxt;
   vxism_lreq_t lreq_r, lreq_nxt;
   logic [15:0] base_r, base_nxt;
   logic [15:0] h2c_r, h2c_nxt;
   logic [15:0] c2h_r, c2h_nxt;
   logic [31:0] route_r, route_nxt;
   logic [3:0] irqc_r, irqc_nxt;
   logic [1:0] stat_r, stat_nxt;
   logic [1:0] mask_r, mask_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] avrd_r, avrd_nxt;
   logic [7:0] vint_r, vint_nxt;
   logic [7:0] trig_r, trig_nxt;
   logic [7:0] oe_r, oe_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic upd_r, upd_nxt;
   logic launch_r, launch_nxt;
   logic a32_r, a32_nxt;
   logic [31:0] cpu_rd;
   logic [15:0] vxi_rd;
   logic mem_hit;
   logic reg_hit;
   logic [1:0] rd_clr;
   logic ev_h2c;
   logic ev_c2h;

   // Switch levels are high when OFF, so the address is the raw bank.
   assign logical_addr = sw_s2.la_off;
   assign flash_wr_en = ~sw_s2.flash_off;
   assign jtag_bypass = ~sw_s2.byp_off;
   assign a32_mode = a32_r;
   assign fw_update_mode = upd_r;
   assign launch_user_app = launch_r;

   // The window follows the strapped size; each half is 16 KB.
   always_comb begin
      if (a32_r) begin
         mem_hit = (v_s2.space == SP_A32) && (v_s2.addr[31:16] == base_r) && !v_s2.addr[15];
      end else begin
         mem_hit = (v_s2.space == SP_A24) && (v_s2.addr[23:16] == base_r[7:0]) && !v_s2.addr[15];
      end
      reg_hit = (v_s2.space == SP_A16) && (v_s2.addr[15:14] == A16_TOP)
         && (v_s2.addr[13:LA_LSB] == logical_addr);
   end

   // Read data for the host side registers.
   always_comb begin
      case (v_s2.addr[5:0])
         V_ID: vxi_rd = {ID_CLASS, (a32_r ? ID_A32 : ID_A24), MFR_ID};
         V_STAT: vxi_rd = {14'h0000, irqc_r[IRQ_EN_BIT], sw_s2.user_off};
         V_BASE: vxi_rd = base_r;
         V_H2C: vxi_rd = h2c_r;
         V_C2H: vxi_rd = c2h_r;
         V_TRG_LO: vxi_rd = route_r[15:0];
         V_TRG_HI: vxi_rd = route_r[31:16];
         default: vxi_rd = 16'h0000;
      endcase
   end

   // Read data for the processor side registers.
   always_comb begin
      case (avs_address)
         C_H2C: cpu_rd = {16'h0000, h2c_r};
         C_C2H: cpu_rd = {16'h0000, c2h_r};
         C_IRQ: cpu_rd = {28'h0000000, irqc_r};
         C_OPS: cpu_rd = {16'h0000, logical_addr, 3'h0, a32_r, flash_wr_en, upd_r, launch_r,
            sw_s2.user_off};
         C_STAT: cpu_rd = {30'h00000000, stat_r};
         C_MASK: cpu_rd = {30'h00000000, mask_r};
         default: cpu_rd = 32'h0000_0000;
      endcase
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign avs_readdata = avrd_r;
   assign vxi_rsp = vrsp_r;
   assign lb_req = lreq_r;
   assign vxi_irq = vint_r;
   assign vxi_trig = trig_r;
   assign vxi_trig_oe = oe_r;
   assign cpu_irq = |(stat_r & mask_r);

   // ----------------------------------------------------------------
   // Next state of the bridge, both register ports and the straps.
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      vrsp_nxt = vrsp_r;
      lreq_nxt = lreq_r;
      base_nxt = base_r;
      h2c_nxt = h2c_r;
      c2h_nxt = c2h_r;
      route_nxt = route_r;
      irqc_nxt = irqc_r;
      mask_nxt = mask_r;
      avrd_nxt = avrd_r;
      cnt_nxt = cnt_r;
      upd_nxt = upd_r;
      launch_nxt = launch_r;
      a32_nxt = a32_r;
      ack_nxt = 1'b0;
      rd_clr = 2'h0;
      ev_h2c = 1'b0;
      ev_c2h = 1'b0;

      // The processor port answers one cycle after the request.
      if ((avs_read | avs_write) && !ack_r) begin
         ack_nxt = 1'b1;
         avrd_nxt = cpu_rd;
      end
      if (ack_r && avs_write) begin
         case (avs_address)
            C_H2C: h2c_nxt = avs_writedata[15:0];
            C_C2H: c2h_nxt = avs_writedata[15:0];
            C_IRQ: irqc_nxt = avs_writedata[3:0];
            C_MASK: mask_nxt = avs_writedata[1:0];
            default: ;
         endcase
      end
      // Only the status bits that the read returned are cleared.
      if (ack_r && avs_read && (avs_address == C_STAT)) begin
         rd_clr = avrd_r[1:0];
      end

      // Host cycles run independently of the processor port.
      case (st_r)
         ST_IDLE: begin
            if (v_s2.req) begin
               if (mem_hit) begin
                  lreq_nxt.req = 1'b1;
                  lreq_nxt.wr = v_s2.wr;
                  lreq_nxt.pci = v_s2.addr[PCI_SEL_BIT];
                  lreq_nxt.addr = v_s2.addr[13:0];
                  lreq_nxt.wdata = v_s2.wdata;
                  st_nxt = ST_LB;
               end else begin
                  vrsp_nxt.ack = reg_hit;
                  vrsp_nxt.rdata = {16'h0000, vxi_rd};
                  st_nxt = ST_DONE;
                  if (reg_hit && v_s2.wr) begin
                     case (v_s2.addr[5:0])
                        V_BASE: base_nxt = v_s2.wdata[15:0];
                        V_H2C: begin
                           h2c_nxt = v_s2.wdata[15:0];
                           ev_h2c = 1'b1;
                        end
                        V_TRG_LO: route_nxt[15:0] = v_s2.wdata[15:0];
                        V_TRG_HI: route_nxt[31:16] = v_s2.wdata[15:0];
                        default: ;
                     endcase
                  end
                  if (reg_hit && !v_s2.wr && (v_s2.addr[5:0] == V_C2H)) begin
                     ev_c2h = 1'b1;
                  end
               end
            end
         end
         ST_LB: begin
            // Local bus request holds until the memory device answers.
            if (lb_rsp.ack) begin
               lreq_nxt.req = 1'b0;
               vrsp_nxt.ack = 1'b1;
               vrsp_nxt.rdata = lb_rsp.rdata;
               st_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            // Acknowledge stays until the host drops its request.
            if (!v_s2.req) begin
               vrsp_nxt.ack = 1'b0;
               st_nxt = ST_IDLE;
            end
         end
         default: st_nxt = ST_IDLE;
      endcase

      // A new event wins over a clear in the same cycle.
      stat_nxt = stat_r & ~rd_clr;
      stat_nxt[ST_H2C_BIT] = stat_nxt[ST_H2C_BIT] | ev_h2c;
      stat_nxt[ST_C2H_BIT] = stat_nxt[ST_C2H_BIT] | ev_c2h;

      // One-hot level drive while the processor holds the enable.
      vint_nxt = irqc_r[IRQ_EN_BIT] ? (8'h01 << irqc_r[2:0]) : 8'h00;

      // Each trigger line takes a nibble: enable over source index.
      for (int i = 0; i < 8; i++) begin
         oe_nxt[i] = route_r[4 * i + 3];
         trig_nxt[i] = route_r[4 * i + 3] & pt_s2[route_r[4 * i +: 3]];
      end

      // Straps are caught once the synchronised switches have settled.
      if (cnt_r != STRAP_WAIT) begin
         cnt_nxt = cnt_r + 2'h1;
         if (cnt_r == STRAP_WAIT - 2'h1) begin
            upd_nxt = sw_s2.update_off;
            launch_nxt = sw_s2.launch_off;
            a32_nxt = ~sw_s2.a32_off;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers of the bridge.
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= ST_IDLE;
         vrsp_r <= '0;
         lreq_r <= '0;
         base_r <= BASE_RST;
         h2c_r <= 16'h0000;
         c2h_r <= 16'h0000;
         route_r <= ROUTE_RST;
         irqc_r <= 4'h0;
         stat_r <= 2'h0;
         mask_r <= 2'h0;
         ack_r <= 1'b0;
         avrd_r <= 32'h0000_0000;
         vint_r <= 8'h00;
         trig_r <= 8'h00;
         oe_r <= 8'h00;
         cnt_r <= 2'h0;
         upd_r <= 1'b0;
         launch_r <= 1'b0;
         a32_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         vrsp_r <= vrsp_nxt;
         lreq_r <= lreq_nxt;
         base_r <= base_nxt;
         h2c_r <= h2c_nxt;
         c2h_r <= c2h_nxt;
         route_r <= route_nxt;
         irqc_r <= irqc_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         ack_r <= ack_nxt;
         avrd_r <= avrd_nxt;
         vint_r <= vint_nxt;
         trig_r <= trig_nxt;
         oe_r <= oe_nxt;
         cnt_r <= cnt_nxt;
         upd_r <= upd_nxt;
         launch_r <= launch_nxt;
         a32_r <= a32_nxt;
      end
   end

endmodule

`default_nettype wire

// ===== vxism_bridge_checker.sv
`timescale 1ns/100ps
`default_nettype none
module vxism_bridge_checker (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire vxism_pkg::vxism_vreq_t vxi_in,
   input wire vxism_pkg::vxism_rsp_t vxi_rsp,
   input wire logic [7:0] vxi_irq,
   input wire vxism_pkg::vxism_lreq_t lb_req,
   input wire vxism_pkg::vxism_rsp_t lb_rsp,
   input wire vxism_pkg::vxism_sw_t sw_in,
   input wire logic [7:0] logical_addr,
   input wire logic a32_mode,
   input wire logic flash_wr_en
);
   import vxism_pkg::*;
   // Every check samples on the system clock and sleeps in reset.
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // Register bus timing, switch copies, local bus and host handshakes, one-hot interrupt levels.
   wait_one_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("wait count wrong");
   idle_rdy_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("idle wait seen");
   wait_again_a: assert property ((avs_read || avs_write) && !avs_waitrequest |=>
      !(avs_read || avs_write) || avs_waitrequest) else $error("wait missing on new request");
   sw_live_a: assert property ($stable(sw_in) [*8] |->
      logical_addr == sw_in.la_off && flash_wr_en == !sw_in.flash_off) else $error("switch copy wrong");
   strap_a: assert property ($stable(sw_in) [*8] |-> a32_mode == !sw_in.a32_off)
      else $error("space strap wrong");
   lb_hold_a: assert property (lb_req.req && !lb_rsp.ack |=> lb_req.req && $stable(lb_req))
      else $error("local request moved");
   lb_done_a: assert property (lb_req.req && lb_rsp.ack |-> ##[1:2] (!lb_req.req && vxi_rsp.ack))
      else $error("local finish wrong");
   ack_rel_a: assert property (!vxi_in.req [*4] |-> !vxi_rsp.ack)
      else $error("host ack stuck");
   irq_hot_a: assert property ($onehot0(vxi_irq))
      else $error("irq not one hot");
   // Main scenarios reached.
   cover property (lb_req.req && lb_rsp.ack);
   cover property (vxi_irq[7]);
   cover property ($rose(avs_write));
endmodule
bind vxism_bridge vxism_bridge_checker u_vxism_bridge_checker (.sys_clk, .nrst, .avs_read, .avs_write,
   .avs_waitrequest, .vxi_in, .vxi_rsp, .vxi_irq, .lb_req, .lb_rsp, .sw_in, .logical_addr, .a32_mode,
   .flash_wr_en);
`default_nettype wire

// ===== vxism_lb_model.sv
`timescale 1ns/100ps
`default_nettype none
module vxism_lb_model (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic slow,
   input wire vxism_pkg::vxism_lreq_t lb_req,
   output var vxism_pkg::vxism_rsp_t lb_rsp
);
   import vxism_pkg::*;
   logic [31:0] mem [0:8191];
   logic [1:0] dly;
   // Answers after zero or three waits; idle read data toggles every cycle.
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         lb_rsp <= '0;
         dly <= 2'h0;
      end else if (lb_req.req && !lb_rsp.ack && (dly == 2'h3 || !slow)) begin
         lb_rsp.ack <= 1'b1;
         lb_rsp.rdata <= mem[{lb_req.pci, lb_req.addr[13:2]}];
         if (lb_req.wr) begin
            mem[{lb_req.pci, lb_req.addr[13:2]}] <= lb_req.wdata;
         end
      end else if (lb_req.req && !lb_rsp.ack) begin
         dly <= dly + 2'h1;
      end else begin
         lb_rsp <= {1'b0, ~lb_rsp.rdata};
         dly <= 2'h0;
      end
   end
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import vxism_pkg::*;
   logic sys_clk, nrst, avs_read, avs_write, avs_waitrequest, cpu_irq, slow, ok;
   logic a32_mode, fw_update_mode, launch_user_app, flash_wr_en;
   logic [4:0] avs_address;
   logic [2:0] jtag_bypass;
   logic [7:0] vxi_irq, pxi_trig, vxi_trig, vxi_trig_oe, logical_addr;
   logic [31:0] avs_writedata, avs_readdata, base, q;
   vxism_vreq_t vxi_in;
   vxism_rsp_t vxi_rsp, lb_rsp;
   vxism_lreq_t lb_req;
   vxism_sw_t sw_in;
   int fails, checks_done, cyc, i;
   vxism_bridge u_vxism_bridge (.sys_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .cpu_irq, .vxi_in, .vxi_rsp, .vxi_irq, .lb_req, .lb_rsp, .pxi_trig,
      .vxi_trig, .vxi_trig_oe, .sw_in, .logical_addr, .a32_mode, .fw_update_mode, .launch_user_app,
      .flash_wr_en, .jtag_bypass);
   vxism_lb_model u_vxism_lb_model (.sys_clk, .nrst, .slow, .lb_req, .lb_rsp);
   // System clock.
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // Cuts a hung run short.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end
   task report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Compares one value and counts the outcome.
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One register transfer, held until waitrequest is sampled low.
   task av(input logic wr, input logic [4:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   // One four-phase host cycle; released lines show inverted values.
   task vx(input logic [1:0] sp, input logic [31:0] a, input logic wr, input logic [31:0] d);
      ok = 1'b0;
      vxi_in <= {1'b1, wr, sp, a, d};
      repeat (30) begin
         @(posedge sys_clk);
         if (!ok && vxi_rsp.ack === 1'b1) begin
            ok = 1'b1;
            q = vxi_rsp.rdata;
         end
      end
      vxi_in <= {1'b0, ~wr, ~sp, ~a, ~d};
      repeat (8) @(posedge sys_clk);
   endtask
   task rst();
      nrst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (8) @(posedge sys_clk);
   endtask
   task t_sw();
      chk(logical_addr, sw_in.la_off);
      chk(flash_wr_en, !sw_in.flash_off);
      chk(jtag_bypass, {~sw_in.byp_off});
      chk({a32_mode, fw_update_mode, launch_user_app}, {!sw_in.a32_off, sw_in.update_off, sw_in.launch_off});
      base = {sw_in.la_off, 3'h0, !sw_in.a32_off, !sw_in.flash_off, sw_in.update_off, sw_in.launch_off, sw_in.user_off};
      av(1'b0, C_OPS, 32'h0);
      chk(q, base);
      av(1'b1, C_OPS, 32'hFFFF);
      av(1'b0, C_OPS, 32'h0);
      chk(q, base);
      av(1'b0, 5'h18, 32'h0);
      chk(q, 32'h0);
      $display("done switches");
   endtask
   task t_hs();
      base = 32'hC000 + {sw_in.la_off, 6'h0};
      av(1'b1, C_MASK, 32'h0);
      vx(SP_A16, base + V_H2C, 1'b1, 32'h1234);
      chk({ok, cpu_irq}, 2'h2);
      av(1'b1, C_MASK, 32'h1);
      chk(cpu_irq, 1'b1);
      av(1'b0, C_H2C, 32'h0);
      chk(q, 32'h1234);
      av(1'b0, C_STAT, 32'h0);
      chk(q, 32'h1);
      chk(cpu_irq, 1'b0);
      av(1'b1, C_C2H, 32'h5A5A);
      vx(SP_A16, base + V_C2H, 1'b0, 32'h0);
      chk(q, 32'h5A5A);
      av(1'b0, C_STAT, 32'h0);
      chk(q, 32'h2);
      chk(cpu_irq, 1'b0);
      $display("done handshake");
   endtask
   task t_mem(input logic a32);
      for (i = 0; i < 6; i++) begin
         slow <= i[0];
         vx(a32 ? SP_A32 : SP_A24, (i % 3 == 2) ? 32'h4000 : 32'h3FFC * (i % 3), i < 3, 32'hC0DE0000 + i);
         chk(ok, 1'b1);
         if (i > 2) begin
            chk(q, 32'hC0DE0000 + i - 3);
         end
      end
      vx(a32 ? SP_A32 : SP_A24, 32'h8000, 1'b0, 32'h0);
      chk(ok, 1'b0);
      vx(a32 ? SP_A24 : SP_A32, 32'h10, 1'b0, 32'h0);
      chk(ok, 1'b0);
      $display("done memory");
   endtask
   task t_irq();
      for (i = 0; i < 9; i++) begin
         av(1'b1, C_IRQ, (i < 8) ? 32'h8 + i : 32'h0);
         @(posedge sys_clk);
         chk(vxi_irq, (i < 8) ? 32'h1 << i : 32'h0);
      end
      $display("done interrupt");
   endtask
   // Host side identity, status and a moved memory window.
   task t_base();
      vx(SP_A16, base + V_ID, 1'b0, 32'h0);
      chk(q, {ID_CLASS, ID_A24, MFR_ID});
      vx(SP_A16, base + V_STAT, 1'b0, 32'h0);
      chk(q, {31'h0, sw_in.user_off});
      vx(SP_A16, base + V_BASE, 1'b1, 32'h12);
      vx(SP_A16, base + V_BASE, 1'b0, 32'h0);
      chk(q, 32'h12);
      vx(SP_A24, 32'h0012_0004, 1'b1, 32'hBEEF0001);
      chk(ok, 1'b1);
      vx(SP_A24, 32'h0012_0004, 1'b0, 32'h0);
      chk(q, 32'hBEEF0001);
      vx(SP_A24, 32'h0000_0004, 1'b0, 32'h0);
      chk(ok, 1'b0);
      $display("done base");
   endtask
   task t_trg();
      vx(SP_A16, base + V_TRG_LO, 1'b1, 32'hB);
      vx(SP_A16, base + V_TRG_HI, 1'b1, 32'h9000);
      pxi_trig <= 8'h08;
      repeat (4) @(posedge sys_clk);
      chk({vxi_trig, vxi_trig_oe}, 16'h0181);
      pxi_trig <= 8'hF7;
      repeat (4) @(posedge sys_clk);
      chk(vxi_trig, 8'h80);
      $display("done triggers");
   endtask
   // Drives every input from time zero, then runs the scenarios.
   initial begin
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h0;
      avs_writedata = 32'h0;
      vxi_in = '0;
      pxi_trig = 8'h0;
      slow = 1'b0;
      sw_in = {8'h24, 5'h1A, 3'h5};
      rst();
      t_sw();
      t_hs();
      t_mem(1'b0);
      t_irq();
      t_base();
      t_trg();
      sw_in <= {8'h81, 5'h05, 3'h0};
      rst();
      t_sw();
      t_mem(1'b1);
      report_and_stop();
   end
endmodule
`default_nettype wire
